// ===== dv/fabric_partner.sv
`timescale 1ns/1ps
module fabric_partner (
  input wire logic core_clk,
  input wire logic stall,
  output logic fab_ready,
  output logic mac_tx_ready
);
  // Accepts every other cycle so sources must hold their words
  logic phase = 1'b0;
  always_ff @(posedge core_clk) phase <= ~phase;
  assign fab_ready = !stall && phase;
  assign mac_tx_ready = !stall && phase;
endmodule // fabric_partner

// ===== dv/port_admission_assertions.sv
`timescale 1ns/1ps
module port_admission_checker (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic fab_valid,
  input wire logic fab_ready,
  input wire logic [4:0] fab_port,
  input wire logic [13:0] fab_len,
  input wire logic mac_tx_valid,
  input wire logic mac_tx_ready,
  input wire logic [13:0] mac_tx_len,
  input wire logic learn_valid,
  input wire logic [4:0] learn_port,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [23:0] pause_request
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic stalled;
  assign stalled = rx_valid && !rx_ready;
  property p_pause; stalled |=> pause_request != 24'h000000; endproperty
  a_pause: assert property (p_pause) else $error("stall without pause");
  property p_pause_cause; $rose(pause_request != 24'h000000) |-> $past(stalled); endproperty
  a_pause_cause: assert property (p_pause_cause) else $error("pause without stall");
  property p_min; fab_valid |-> fab_len >= 14'h0040; endproperty
  a_min: assert property (p_min) else $error("runt forwarded");
  property p_max; fab_valid |-> fab_len <= 14'h2400; endproperty
  a_max: assert property (p_max) else $error("oversize forwarded");
  property p_port; fab_valid |-> fab_port < 5'h18; endproperty
  a_port: assert property (p_port) else $error("bad port forwarded");
  property p_fab_hold; fab_valid && !fab_ready |=> fab_valid && $stable(fab_len); endproperty
  a_fab_hold: assert property (p_fab_hold) else $error("fabric word lost");
  property p_tx_hold; mac_tx_valid && !mac_tx_ready |=> mac_tx_valid && $stable(mac_tx_len); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("egress word lost");
  property p_learn; learn_valid |-> learn_port < 5'h18; endproperty
  a_learn: assert property (p_learn) else $error("learn on bad port");
  property p_bresp; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bresp: assert property (p_bresp) else $error("write response dropped");
  c_fab: cover property (fab_valid && fab_ready);
  c_pause: cover property (stalled ##1 pause_request != 24'h000000);
  c_tx: cover property (mac_tx_valid && !mac_tx_ready);
endmodule // port_admission_checker
bind switch_port_admission_control port_admission_checker port_admission_checker_inst (.*);

// ===== dv/test_switch_port_admission_control.sv
`timescale 1ns/1ps
module test_switch_port_admission_control;
  logic core_clk, rstn, stall, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rx_valid, rx_ready, rx_crc_ok;
  logic rx_bcast, rx_mcast, rx_src_known, learn_valid, fab_valid, fab_ready, tx_valid, tx_ready;
  logic mac_tx_valid, mac_tx_ready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [47:0] an_speed, frame_source_address, learn_address, link_speed;
  logic [23:0] an_duplex, port_enable, link_duplex, pause_request;
  logic [4:0] rx_port, learn_port, fab_port, tx_port, mac_tx_port;
  logic [13:0] rx_len, fab_len, tx_len, mac_tx_len;
  int failures = 0;
  int total_checks = 0;
  switch_port_admission_control #(.ACCT_CYCLES(64)) switch_port_admission_control_inst (.*);
  fabric_partner fabric_partner_inst (.core_clk, .stall, .fab_ready, .mac_tx_ready);
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    if (failures == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ah, wh, bh;
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'h3};
    do begin
      @(negedge core_clk);
      {ah, wh, bh} = {s_axi_awvalid && s_axi_awready, s_axi_wvalid && s_axi_wready, s_axi_bvalid};
      @(posedge core_clk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
    end while (!bh);
    check(s_axi_bresp, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ah, got;
    {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
    do begin
      @(negedge core_clk);
      {ah, got} = {s_axi_arvalid && s_axi_arready, s_axi_rvalid};
      @(posedge core_clk);
      if (ah) s_axi_arvalid <= 1'b0;
    end while (!got);
    check(s_axi_rdata, d);
    check(s_axi_rresp, e);
  endtask
  // Egress when tx is set, ingress otherwise; valid held until ready is seen or 300 cycles pass
  task automatic send(input logic tx, input logic [4:0] p, input logic [13:0] l, input logic known);
    logic hit;
    int n = 0;
    if (tx) {tx_port, tx_len, tx_valid} <= {p, l, 1'b1};
    else {rx_port, rx_len, rx_src_known, rx_valid} <= {p, l, known, 1'b1};
    do begin
      @(negedge core_clk);
      hit = tx ? tx_ready : rx_ready;
      n++;
      @(posedge core_clk);
    end while (!hit && n < 300);
    if (tx) tx_valid <= 1'b0;
    else rx_valid <= 1'b0;
    check(hit, 1'b1);
    @(posedge core_clk);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    #400us;
    failures++;
    give_verdict;
  end
  initial begin
    {rstn, stall, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, rx_valid} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, an_speed, an_duplex, rx_bcast, rx_mcast, tx_valid} = '0;
    {rx_port, rx_len, rx_src_known, tx_port, tx_len, frame_source_address} = '0;
    {s_axi_wstrb, rx_crc_ok, s_axi_bready, s_axi_rready} = 7'h7F;
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(12'h000, 32'h21, 2'h0);
    wr(12'h000, 32'h0F, 2'h0);
    rd(12'h000, 32'h0F, 2'h0);
    check(link_speed[1:0], 2'h3);
    wr(12'h0DC, 32'h5, 2'h0);
    rd(12'h0DC, 32'h5, 2'h0);
    rd(12'h0E0, 32'h0, 2'h2);
    stall <= 1'b1;
    repeat (3) send(1'b0, 5'h00, 14'h0040, 1'b1);
    rd(12'h300, 32'h1, 2'h0);
    wr(12'h000, 32'h2F, 2'h0);
    fork
      send(1'b0, 5'h00, 14'h0040, 1'b1);
      begin
        repeat (6) @(posedge core_clk);
        check(rx_ready, 1'b0);
        check(pause_request[0], 1'b1);
        stall <= 1'b0;
      end
    join
    rd(12'h200, 32'h4, 2'h0);
    send(1'b0, 5'h01, 14'h003F, 1'b1);
    send(1'b0, 5'h01, 14'h2400, 1'b1);
    wr(12'h004, 32'h135, 2'h0);
    send(1'b0, 5'h01, 14'h2400, 1'b1);
    send(1'b0, 5'h01, 14'h2401, 1'b1);
    rd(12'h284, 32'h3, 2'h0);
    rd(12'h204, 32'h1, 2'h0);
    wr(12'h008, 32'h34, 2'h0);
    send(1'b0, 5'h02, 14'h0040, 1'b1);
    rd(12'h208, 32'h0, 2'h0);
    check(port_enable[2], 1'b0);
    wr(12'h00C, 32'h75, 2'h0);
    send(1'b0, 5'h03, 14'h0040, 1'b0);
    send(1'b0, 5'h03, 14'h0040, 1'b1);
    rd(12'h30C, 32'h1, 2'h0);
    wr(12'h010, 32'h15, 2'h0);
    wr(12'h090, 32'd9000, 2'h0);
    rd(12'h090, 32'h1F40, 2'h0);
    wr(12'h090, 32'h1, 2'h0);
    // One refill of 16 octets admits a single 64 octet frame, the debt blocks the rest
    repeat (70) @(posedge core_clk);
    repeat (3) send(1'b0, 5'h04, 14'h0040, 1'b1);
    rd(12'h210, 32'h3, 2'h0);
    rd(12'h310, 32'h2, 2'h0);
    wr(12'h114, 32'd9000, 2'h0);
    rd(12'h114, 32'h1F40, 2'h0);
    send(1'b1, 5'h05, 14'h0064, 1'b1);
    repeat (2) @(posedge core_clk);
    check({mac_tx_port, mac_tx_len}, {5'h05, 14'h0064});
    give_verdict;
  end
endmodule // test_switch_port_admission_control

// ===== logic/port_admission_pkg.sv
package port_admission_pkg;

  localparam int PORT_COUNT = 24;
  localparam int PORT_W = 5;
  localparam int LEN_W = 14;
  localparam int RATE_W = 13;
  localparam int ADDR_W = 12;

  // Register byte offsets
  localparam logic [11:0] CTRL_BASE = 12'h000;
  localparam logic [11:0] INGRESS_BASE = 12'h080;
  localparam logic [11:0] EGRESS_BASE = 12'h100;
  localparam logic [11:0] STORM_CFG_OFFSET = 12'h180;
  localparam logic [11:0] RX_GOOD_BASE = 12'h200;
  localparam logic [11:0] RX_BAD_BASE = 12'h280;
  localparam logic [11:0] DROP_BASE = 12'h300;
  localparam logic [11:0] BANK_MASK = 12'hF80;

  // Port control fields
  localparam int CTRL_W = 9;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_FORCE_BIT = 1;
  localparam int CTRL_SPEED_LSB = 2;
  localparam int CTRL_DUPLEX_BIT = 4;
  localparam int CTRL_FLOW_BIT = 5;
  localparam int CTRL_SECURE_BIT = 6;
  localparam int CTRL_STORM_BIT = 7;
  localparam int CTRL_JUMBO_BIT = 8;
  localparam logic [8:0] CTRL_RESET = 9'h035;

  // Storm configuration fields
  localparam int STORM_CFG_W = 9;
  localparam int STORM_MCAST_BIT = 8;
  localparam logic [8:0] STORM_CFG_RESET = 9'h040;

  localparam logic [12:0] RATE_RESET = 13'h0000;
  localparam logic [12:0] RATE_MAX = 13'h1F40;

  // Frame lengths in octets
  localparam logic [13:0] MIN_FRAME_LEN = 14'h0040;
  localparam logic [13:0] MAX_STD_LEN = 14'h05EE;
  localparam logic [13:0] MAX_JUMBO_LEN = 14'h2400;

  // Accounting: 128 kbit/s per unit is 16 octets per millisecond
  localparam int CLOCK_MHZ = 40;
  localparam int ACCT_INTERVAL_US = 1000;
  localparam int ACCT_INTERVAL_CYCLES = ACCT_INTERVAL_US * CLOCK_MHZ;
  localparam int OCTETS_PER_UNIT = 16;
  localparam int BURST_INTERVALS = 2;

  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

endpackage

// ===== logic/rate_bucket.sv
`timescale 1ns/1ps
module rate_bucket #(
  parameter int RATE_W = 13,
  parameter int LEN_W = 14
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic [RATE_W-1:0] rate,
  input wire logic consume,
  input wire logic [LEN_W-1:0] len,
  output logic allow
);
  localparam int TOK_W = 25;
  logic signed [TOK_W-1:0] tokens, next_tokens, refill, cap, sum;

  assign refill = TOK_W'(rate) * TOK_W'(port_admission_pkg::OCTETS_PER_UNIT);
  assign cap = refill * TOK_W'(port_admission_pkg::BURST_INTERVALS);
  // A whole frame may overdraw the allowance; the debt delays later frames
  assign allow = (rate == '0) || (tokens > 0);

  always_comb begin
    sum = tokens;
    if (tick) begin
      sum = (tokens + refill > cap) ? cap : tokens + refill;
    end
    next_tokens = consume ? sum - TOK_W'(len) : sum;
    if (rate == '0) begin
      next_tokens = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tokens <= '0;
    end else begin
      tokens <= next_tokens;
    end
  end
endmodule // rate_bucket

// ===== logic/switch_port_admission_control.sv
// Overview of operation
// - Disabled port neither receives nor transmits frames
// - Auto uses negotiated, forced uses configured speed
// - Speed/duplex writable only when forced
// - Flow control on: overload raises pause request
// - Flow control off: overload drops excess frames
// - Ingress limit 0..8000 units, zero disables
// - Egress limit 0..8000 units, zero disables
// - Separate ingress and egress limits per port
// - Secure port forwards only known source addresses
// - Per-port storm enable, shared storm settings
// - Jumbo enabled port forwards oversized frames
// - Jumbo frames accepted up to 9 Kbytes
// - Frames under 64 octets counted bad
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module switch_port_admission_control #(
  parameter int ACCT_CYCLES = port_admission_pkg::ACCT_INTERVAL_CYCLES,
  parameter int FIFO_DEPTH = 2
) (
  input wire logic core_clk,
  input wire logic rstn,
  // AXI4-Lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Negotiated results from the PHYs
  input wire logic [47:0] an_speed,
  input wire logic [23:0] an_duplex,
  // Received frame descriptors from the MACs
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [4:0] rx_port,
  input wire logic [13:0] rx_len,
  input wire logic rx_crc_ok,
  input wire logic rx_bcast,
  input wire logic rx_mcast,
  input wire logic rx_src_known,
  input wire logic [47:0] frame_source_address,
  // Address learning requests
  output logic learn_valid,
  output logic [47:0] learn_address,
  output logic [4:0] learn_port,
  // Admitted frames towards the fabric
  output logic fab_valid,
  input wire logic fab_ready,
  output logic [4:0] fab_port,
  output logic [13:0] fab_len,
  // Frames from the fabric to transmit
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [4:0] tx_port,
  input wire logic [13:0] tx_len,
  output logic mac_tx_valid,
  input wire logic mac_tx_ready,
  output logic [4:0] mac_tx_port,
  output logic [13:0] mac_tx_len,
  // Per-port control towards MAC/PHY
  output logic [23:0] port_enable,
  output logic [47:0] link_speed,
  output logic [23:0] link_duplex,
  output logic [23:0] pause_request
);
  localparam int N = port_admission_pkg::PORT_COUNT;
  localparam int FW = port_admission_pkg::PORT_W + port_admission_pkg::LEN_W;
  localparam int CNT_W = $clog2(ACCT_CYCLES);

  ////////////////////////////////////////////////////////////////////////////
  logic rst_sync1, rst_n;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_sync1 <= 1'b1;
      rst_n <= rst_sync1;
    end
  end

  function automatic logic [4:0] word_index(input logic [11:0] addr);
    word_index = addr[6:2];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      old[8*b +: 8] = strb[b] ? data[8*b +: 8] : old[8*b +: 8];
    end
    merge = old;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Configuration and statistics storage
  logic [8:0] port_ctrl [N];
  logic [12:0] ingress_rate [N];
  logic [12:0] egress_rate [N];
  logic [8:0] storm_cfg;
  logic [31:0] rx_good_cnt [N];
  logic [31:0] rx_bad_cnt [N];
  logic [31:0] drop_cnt [N];
  logic [7:0] storm_cnt [N];

  // Accounting interval tick
  logic [CNT_W-1:0] acct_cnt, next_acct_cnt;
  logic tick;
  assign tick = (acct_cnt == CNT_W'(ACCT_CYCLES - 1));
  always_comb begin
    next_acct_cnt = tick ? '0 : acct_cnt + 1'b1;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acct_cnt <= '0;
    end else begin
      acct_cnt <= next_acct_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic aw_full, w_full, next_aw_full, next_w_full, next_bvalid, next_rvalid;
  logic [11:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data, next_rdata, rd_word;
  logic [3:0] w_strb, next_w_strb;
  logic [1:0] next_bresp, next_rresp;
  logic do_write, wr_mapped, rd_mapped;
  logic [4:0] widx, ridx;
  logic [11:0] wbank;

  assign s_axi_awready = !aw_full;
  assign s_axi_wready = !w_full;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_full && w_full && !s_axi_bvalid;
  assign widx = word_index(aw_addr);
  assign ridx = word_index(s_axi_araddr);
  assign wbank = aw_addr & port_admission_pkg::BANK_MASK;
  assign wr_mapped = (widx < 5'(N) && (wbank == port_admission_pkg::CTRL_BASE ||
      wbank == port_admission_pkg::INGRESS_BASE || wbank == port_admission_pkg::EGRESS_BASE)) ||
      aw_addr == port_admission_pkg::STORM_CFG_OFFSET;

  always_comb begin
    rd_mapped = 1'b1;
    rd_word = 32'h00000000;
    if (s_axi_araddr == port_admission_pkg::STORM_CFG_OFFSET) begin
      rd_word = 32'(storm_cfg);
    end else if (ridx >= 5'(N) || s_axi_araddr[1:0] != 2'h0) begin
      rd_mapped = 1'b0;
    end else begin
      unique case (s_axi_araddr & port_admission_pkg::BANK_MASK)
        port_admission_pkg::CTRL_BASE: begin
          rd_word = 32'(port_ctrl[ridx]);
          if (!port_ctrl[ridx][port_admission_pkg::CTRL_FORCE_BIT]) begin
            rd_word[port_admission_pkg::CTRL_SPEED_LSB +: 2] = an_speed[2*ridx +: 2];
            rd_word[port_admission_pkg::CTRL_DUPLEX_BIT] = an_duplex[ridx];
          end
        end
        port_admission_pkg::INGRESS_BASE: rd_word = 32'(ingress_rate[ridx]);
        port_admission_pkg::EGRESS_BASE: rd_word = 32'(egress_rate[ridx]);
        port_admission_pkg::RX_GOOD_BASE: rd_word = rx_good_cnt[ridx];
        port_admission_pkg::RX_BAD_BASE: rd_word = rx_bad_cnt[ridx];
        port_admission_pkg::DROP_BASE: rd_word = drop_cnt[ridx];
        default: rd_mapped = 1'b0;
      endcase
    end
  end

  always_comb begin
    {next_aw_full, next_aw_addr, next_w_full, next_w_data, next_w_strb} = {aw_full, aw_addr, w_full, w_data, w_strb};
    {next_bvalid, next_bresp} = {s_axi_bvalid, s_axi_bresp};
    {next_rvalid, next_rdata, next_rresp} = {s_axi_rvalid, s_axi_rdata, s_axi_rresp};
    if (s_axi_awvalid && !aw_full) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_full) begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_mapped ? port_admission_pkg::AXI_OKAY : port_admission_pkg::AXI_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_axi_rvalid) begin
      next_rvalid = 1'b1;
      next_rdata = rd_word;
      next_rresp = rd_mapped ? port_admission_pkg::AXI_OKAY : port_admission_pkg::AXI_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {aw_full, aw_addr, w_full, w_data, w_strb} <= '0;
      {s_axi_bvalid, s_axi_bresp, s_axi_rvalid, s_axi_rdata, s_axi_rresp} <= '0;
    end else begin
      {aw_full, aw_addr, w_full, w_data, w_strb} <= {next_aw_full, next_aw_addr, next_w_full, next_w_data, next_w_strb};
      {s_axi_bvalid, s_axi_bresp} <= {next_bvalid, next_bresp};
      {s_axi_rvalid, s_axi_rdata, s_axi_rresp} <= {next_rvalid, next_rdata, next_rresp};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ingress admission
  logic rx_port_ok, rx_fc, size_bad, storm_hit, ing_ok;
  logic rx_accept, rx_forward, rx_drop, rx_stall, fifo_in_ready;
  logic [4:0] rp;
  logic [13:0] max_len;
  logic [N-1:0] ing_allow, egr_allow, ing_take, egr_take, next_pause;

  assign rx_port_ok = rx_port < 5'(N);
  assign rp = rx_port_ok ? rx_port : 5'h00;
  assign rx_fc = port_ctrl[rp][port_admission_pkg::CTRL_FLOW_BIT];
  assign max_len = port_ctrl[rp][port_admission_pkg::CTRL_JUMBO_BIT] ?
      port_admission_pkg::MAX_JUMBO_LEN : port_admission_pkg::MAX_STD_LEN;
  assign size_bad = rx_len < port_admission_pkg::MIN_FRAME_LEN || rx_len > max_len || !rx_crc_ok;
  assign storm_hit = port_ctrl[rp][port_admission_pkg::CTRL_STORM_BIT] &&
      (rx_bcast || (rx_mcast && storm_cfg[port_admission_pkg::STORM_MCAST_BIT])) &&
      storm_cnt[rp] >= storm_cfg[7:0];
  assign ing_ok = ing_allow[rp] && fifo_in_ready;

  always_comb begin
    rx_forward = 1'b0;
    rx_drop = 1'b0;
    rx_stall = 1'b0;
    if (rx_valid) begin
      if (!rx_port_ok || !port_ctrl[rp][port_admission_pkg::CTRL_ENABLE_BIT]) begin
        rx_drop = 1'b1;
      end else if (size_bad) begin
        rx_drop = 1'b1;
      end else if (port_ctrl[rp][port_admission_pkg::CTRL_SECURE_BIT] && !rx_src_known) begin
        rx_drop = 1'b1;
      end else if (storm_hit) begin
        rx_drop = 1'b1;
      end else if (ing_ok) begin
        rx_forward = 1'b1;
      end else if (rx_fc) begin
        rx_stall = 1'b1;
      end else begin
        rx_drop = 1'b1;
      end
    end
    rx_accept = rx_forward || rx_drop;
    next_pause = '0;
    next_pause[rp] = rx_stall;
  end

  assign rx_ready = !rx_stall;

  // Per-port counters; a frame of a disabled port is not counted as received
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < N; i++) begin
        {rx_good_cnt[i], rx_bad_cnt[i], drop_cnt[i], storm_cnt[i]} <= '0;
      end
      {pause_request, learn_valid, learn_address, learn_port} <= '0;
    end else begin
      pause_request <= next_pause;
      learn_valid <= rx_forward && !rx_src_known;
      if (rx_forward) begin
        learn_address <= frame_source_address;
        learn_port <= rx_port;
      end
      for (int i = 0; i < N; i++) begin
        if (tick) begin
          storm_cnt[i] <= 8'h00;
        end else if (rx_forward && rp == 5'(i) && (rx_bcast || rx_mcast) && storm_cnt[i] != 8'hFF) begin
          storm_cnt[i] <= storm_cnt[i] + 8'h01;
        end
      end
      if (rx_accept && rx_port_ok && port_ctrl[rp][port_admission_pkg::CTRL_ENABLE_BIT]) begin
        if (size_bad) begin
          rx_bad_cnt[rp] <= rx_bad_cnt[rp] + 32'h00000001;
        end else begin
          rx_good_cnt[rp] <= rx_good_cnt[rp] + 32'h00000001;
        end
        if (rx_drop) begin
          drop_cnt[rp] <= drop_cnt[rp] + 32'h00000001;
        end
      end
    end
  end

  two_entry_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fab_fifo (
    .clk(core_clk),
    .rst_n(rst_n),
    .in_valid(rx_forward),
    .in_ready(fifo_in_ready),
    .in_data({rx_port, rx_len}),
    .out_valid(fab_valid),
    .out_ready(fab_ready),
    .out_data({fab_port, fab_len})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Egress gating
  logic tx_port_ok, tx_en, tx_load, next_mac_valid;
  logic [4:0] tp;
  assign tx_port_ok = tx_port < 5'(N);
  assign tp = tx_port_ok ? tx_port : 5'h00;
  assign tx_en = tx_port_ok && port_ctrl[tp][port_admission_pkg::CTRL_ENABLE_BIT];
  // Frames for a disabled port are swallowed so the fabric never blocks on it
  assign tx_load = tx_valid && tx_en && egr_allow[tp] && (!mac_tx_valid || mac_tx_ready);
  assign tx_ready = !tx_en || tx_load;

  always_comb begin
    next_mac_valid = mac_tx_valid;
    if (tx_load) begin
      next_mac_valid = 1'b1;
    end else if (mac_tx_ready) begin
      next_mac_valid = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {mac_tx_valid, mac_tx_port, mac_tx_len} <= '0;
    end else begin
      mac_tx_valid <= next_mac_valid;
      if (tx_load) begin
        mac_tx_port <= tx_port;
        mac_tx_len <= tx_len;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-port configuration, buckets and link settings
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_port
      logic [31:0] wval;
      logic wsel;
      assign wsel = do_write && widx == 5'(g);
      assign ing_take[g] = rx_forward && rp == 5'(g);
      assign egr_take[g] = tx_load && tp == 5'(g);

      always_comb begin
        unique case (wbank)
          port_admission_pkg::INGRESS_BASE: wval = merge(32'(ingress_rate[g]), w_data, w_strb);
          port_admission_pkg::EGRESS_BASE: wval = merge(32'(egress_rate[g]), w_data, w_strb);
          default: wval = merge(32'(port_ctrl[g]), w_data, w_strb);
        endcase
      end

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          port_ctrl[g] <= port_admission_pkg::CTRL_RESET;
          ingress_rate[g] <= port_admission_pkg::RATE_RESET;
          egress_rate[g] <= port_admission_pkg::RATE_RESET;
          {link_speed[2*g +: 2], link_duplex[g], port_enable[g]} <= '0;
        end else begin
          if (wsel && wbank == port_admission_pkg::CTRL_BASE) begin
            port_ctrl[g] <= wval[8:0];
            if (!wval[port_admission_pkg::CTRL_FORCE_BIT]) begin
              port_ctrl[g][port_admission_pkg::CTRL_SPEED_LSB +: 2] <=
                  port_ctrl[g][port_admission_pkg::CTRL_SPEED_LSB +: 2];
              port_ctrl[g][port_admission_pkg::CTRL_DUPLEX_BIT] <= port_ctrl[g][port_admission_pkg::CTRL_DUPLEX_BIT];
            end
          end
          if (wsel && wbank == port_admission_pkg::INGRESS_BASE) begin
            ingress_rate[g] <= (wval > 32'(port_admission_pkg::RATE_MAX)) ? port_admission_pkg::RATE_MAX : wval[12:0];
          end
          if (wsel && wbank == port_admission_pkg::EGRESS_BASE) begin
            egress_rate[g] <= (wval > 32'(port_admission_pkg::RATE_MAX)) ? port_admission_pkg::RATE_MAX : wval[12:0];
          end
          port_enable[g] <= port_ctrl[g][port_admission_pkg::CTRL_ENABLE_BIT];
          link_speed[2*g +: 2] <= port_ctrl[g][port_admission_pkg::CTRL_FORCE_BIT] ?
              port_ctrl[g][port_admission_pkg::CTRL_SPEED_LSB +: 2] : an_speed[2*g +: 2];
          link_duplex[g] <= port_ctrl[g][port_admission_pkg::CTRL_FORCE_BIT] ?
              port_ctrl[g][port_admission_pkg::CTRL_DUPLEX_BIT] : an_duplex[g];
        end
      end

      rate_bucket u_ing (
        .clk(core_clk),
        .rst_n(rst_n),
        .tick(tick),
        .rate(ingress_rate[g]),
        .consume(ing_take[g]),
        .len(rx_len),
        .allow(ing_allow[g])
      );

      rate_bucket u_egr (
        .clk(core_clk),
        .rst_n(rst_n),
        .tick(tick),
        .rate(egress_rate[g]),
        .consume(egr_take[g]),
        .len(tx_len),
        .allow(egr_allow[g])
      );
    end
  endgenerate

  logic [31:0] storm_wval;
  logic [8:0] next_storm_cfg;
  always_comb begin
    storm_wval = merge(32'(storm_cfg), w_data, w_strb);
    next_storm_cfg = storm_cfg;
    if (do_write && aw_addr == port_admission_pkg::STORM_CFG_OFFSET) begin
      next_storm_cfg = storm_wval[8:0];
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      storm_cfg <= port_admission_pkg::STORM_CFG_RESET;
    end else begin
      storm_cfg <= next_storm_cfg;
    end
  end
endmodule // switch_port_admission_control

// ===== logic/two_entry_fifo.sv
`timescale 1ns/1ps
module two_entry_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [CNT_W-1:0] count, next_count;
  logic push, pop;

  assign in_ready = (count != FULL);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage needs no reset; out_valid masks stale entries
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule // two_entry_fifo
